// file: logic/ppm_pkg.sv
// constants shared by the port pin function multiplexer and its slices
// assumes a single 100 MHz clock and an asynchronous active-high reset
//
// Notes on behaviour
// RULE1 - every port bit owns select, direction, latch, input, enable, flag, edge bits
// RULE2 - pin driver enable always follows the direction bit, even in peripheral mode
// RULE3 - port 1 bit 0 drives constant low in peripheral mode
// RULE4 - port 1 bit 0 input goes to the timer external clock
// RULE5 - port 1 bits 1 to 3 drive compare outputs 0 to 2 in peripheral mode
// RULE6 - port 1 bits 1 to 3 inputs feed capture channels 0 to 2, choice a
// RULE7 - port 1 bit 4 drives the subsystem master clock in peripheral mode
// RULE8 - port 1 bits 5 to 7 drive compare outputs 0 to 2, feed nothing
// RULE9 - port 2 bit 0 drives the auxiliary clock, input feeds nothing
// RULE10 - port 2 bit 1 input is the timer alternate clock, output constant low
// RULE11 - port 2 bit 2 drives comparator result, input is capture 0 choice b
// RULE12 - port 2 bits 3 and 4 drive compare outputs 1 and 2, feed nothing
// RULE13 - port 2 bit 5 is oscillator resistor pin, output low, input unused
// RULE14 - port 2 bits 6 and 7 are unbonded but keep their full slice
// RULE15 - unbonded port 2 flags serve as software interrupt sources
// RULE16 - unbonded port 2 flags change only by software writes
// RULE17 - flag sets on selected edge, 0 rising 1 falling; request needs enable
// RULE18 - with select clear the latch drives the pin if direction set

package ppm_pkg;
    localparam int   PORT_WIDTH      = 8;
    localparam int   P2_BONDED       = 6;
    localparam int   SYNC_STAGES     = 3;
    localparam logic RST_FLAG        = 1'b0;
    localparam logic RST_SYNC        = 1'b0;
    localparam logic EDGE_RISING     = 1'b0;
    localparam logic PERIPH_LOW      = 1'b0;
    // port 1 bit positions
    localparam int   P1_EXT_CLK_BIT  = 0;
    localparam int   P1_CAP0_BIT     = 1;
    localparam int   P1_CAP1_BIT     = 2;
    localparam int   P1_CAP2_BIT     = 3;
    localparam int   P1_SUBSYSTEM_MASTER_CLOCK_BIT    = 4;
    // port 2 bit positions
    localparam int   P2_ACLK_BIT     = 0;
    localparam int   P2_ALT_CLK_BIT  = 1;
    localparam int   P2_COMP_BIT     = 2;
    localparam int   P2_OSC_RES_BIT  = 5;
endpackage

// file: logic/ppm_slice_if.sv
// carrier between the port top and one per-pin control slice
// assumes the top drives the control side and the slice the pad side
`timescale 1ns/1ps
interface ppm_slice_if;
    logic pin_function_select;
    logic pin_direction_bit;
    logic pin_output_latch;
    logic pin_irq_enable;
    logic pin_edge_select;
    logic periph_out;
    logic pin_sync;
    logic flag_wr;
    logic flag_wdata;
    logic pad_out;
    logic pad_oe;
    logic pin_input_value;
    logic pin_irq_flag;
    logic irq_req;

    modport ctrl (
        output pin_function_select, pin_direction_bit, pin_output_latch,
        output pin_irq_enable, pin_edge_select, periph_out, pin_sync, flag_wr, flag_wdata,
        input  pad_out, pad_oe, pin_input_value, pin_irq_flag, irq_req
    );
    modport slice (
        input  pin_function_select, pin_direction_bit, pin_output_latch,
        input  pin_irq_enable, pin_edge_select, periph_out, pin_sync, flag_wr, flag_wdata,
        output pad_out, pad_oe, pin_input_value, pin_irq_flag, irq_req
    );
endinterface

// file: logic/ppm_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to i_ref_clk
`timescale 1ns/1ps
module ppm_sync3
    import ppm_pkg::*;
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    // async in, filtered out
    input  wire logic i_async,
    output logic      o_value
);
    typedef struct packed {
        logic [SYNC_STAGES-1:0] chain;
        logic                   value;
    } ppm_sync_state_t;

    ppm_sync_state_t st_q;
    ppm_sync_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.chain = {st_q.chain[SYNC_STAGES-2:0], i_async};
        // only stages two and three are compared; stage one may be metastable
        if (st_q.chain[1] == st_q.chain[2])
        begin
            st_d.value = st_q.chain[1];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_q <= '{chain: '0, value: RST_SYNC};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_value = st_q.value;
endmodule

// file: logic/ppm_pin_slice.sv
// one pin control slice: output mux, driver enable, edge flag, request
// assumes pin_sync is already synchronised to i_ref_clk
`timescale 1ns/1ps
module ppm_pin_slice
    import ppm_pkg::*;
#(
    parameter bit HAS_PIN = 1'b1
)
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    // control and pad side
    ppm_slice_if.slice sif
);
    typedef struct packed {
        logic prev;
        logic flag;
    } ppm_slice_state_t;

    ppm_slice_state_t st_q;
    ppm_slice_state_t st_d;
    logic             cur;
    logic             edge_hit;

    // unbonded bits see a constant low input, so no edge can ever occur
    assign cur = HAS_PIN ? sif.pin_sync : 1'b0; // RULE16

    always_comb
    begin
        st_d = st_q;
        st_d.prev = cur;
        edge_hit = HAS_PIN && ((sif.pin_edge_select == EDGE_RISING) ? (cur && !st_q.prev)
                                                                     : (!cur && st_q.prev)); // RULE17
        if (sif.flag_wr)
        begin
            st_d.flag = sif.flag_wdata; // RULE15
        end
        // an edge in the same cycle as a clearing write still sets the flag
        if (edge_hit)
        begin
            st_d.flag = 1'b1; // RULE17
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_q <= '{prev: 1'b0, flag: RST_FLAG};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sif.pad_out         = sif.pin_function_select ? sif.periph_out : sif.pin_output_latch; // RULE18
    assign sif.pad_oe          = sif.pin_direction_bit; // RULE2
    assign sif.pin_input_value = cur; // RULE1
    assign sif.pin_irq_flag    = st_q.flag;
    assign sif.irq_req         = st_q.flag & sif.pin_irq_enable; // RULE17
endmodule

// file: logic/ppm_port_mux.sv
// two 8-bit ports with per-bit peripheral function multiplexing
// assumes timer, clock and comparator signals are on i_ref_clk or are clocks to be forwarded
`timescale 1ns/1ps
module ppm_port_mux
    import ppm_pkg::*;
#(
    parameter int P1_W = PORT_WIDTH,
    parameter int P2_W = PORT_WIDTH
)
(
    // clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_reset,
    // port 1 control
    input  wire logic [P1_W-1:0] i_p1_function_select,
    input  wire logic [P1_W-1:0] i_p1_direction_bit,
    input  wire logic [P1_W-1:0] i_p1_output_latch,
    input  wire logic [P1_W-1:0] i_p1_irq_enable,
    input  wire logic [P1_W-1:0] i_p1_edge_select,
    input  wire logic            i_p1_flag_wr,
    input  wire logic [P1_W-1:0] i_p1_flag_wdata,
    // port 2 control
    input  wire logic [P2_W-1:0] i_p2_function_select,
    input  wire logic [P2_W-1:0] i_p2_direction_bit,
    input  wire logic [P2_W-1:0] i_p2_output_latch,
    input  wire logic [P2_W-1:0] i_p2_irq_enable,
    input  wire logic [P2_W-1:0] i_p2_edge_select,
    input  wire logic            i_p2_flag_wr,
    input  wire logic [P2_W-1:0] i_p2_flag_wdata,
    // port status
    output logic      [P1_W-1:0] o_p1_pin_input_value,
    output logic      [P1_W-1:0] o_p1_pin_irq_flag,
    output logic                 o_p1_irq,
    output logic      [P2_W-1:0] o_p2_pin_input_value,
    output logic      [P2_W-1:0] o_p2_pin_irq_flag,
    output logic                 o_p2_irq,
    // pads
    input  wire logic [P1_W-1:0] i_p1_pin,
    output logic      [P1_W-1:0] o_p1_pin,
    output logic      [P1_W-1:0] o_p1_pin_oe,
    input  wire logic [P2_BONDED-1:0] i_p2_pin,
    output logic      [P2_BONDED-1:0] o_p2_pin,
    output logic      [P2_BONDED-1:0] o_p2_pin_oe,
    // peripheral sources
    input  wire logic            i_compare0_output,
    input  wire logic            i_compare1_output,
    input  wire logic            i_compare2_output,
    input  wire logic            i_subsystem_master_clock,
    input  wire logic            i_aux_clock,
    input  wire logic            i_comparator_result,
    // peripheral sinks
    output logic                 o_timer_ext_clock_in,
    output logic                 o_timer_alt_clock_in,
    output logic                 o_capture0_input_a,
    output logic                 o_capture1_input_a,
    output logic                 o_capture2_input_a,
    output logic                 o_capture0_input_b,
    output logic                 o_oscillator_resistor_pin
);
    // the peripheral bit map is fixed, so other widths are refused at elaboration
    if (P1_W != PORT_WIDTH || P2_W != PORT_WIDTH)
    begin : g_bad_width
        $error("ppm_port_mux serves only 8-bit ports");
    end

    logic [P1_W-1:0] p1_sync;
    logic [P2_W-1:0] p2_sync;
    logic [P1_W-1:0] p1_periph;
    logic [P2_W-1:0] p2_periph;
    logic [P1_W-1:0] p1_pad_out;
    logic [P1_W-1:0] p1_pad_oe;
    logic [P2_W-1:0] p2_pad_out;
    logic [P2_W-1:0] p2_pad_oe;
    logic [P1_W-1:0] p1_req;
    logic [P2_W-1:0] p2_req;

    // peripheral output value per bit; clock outputs pass straight through, unregistered
    assign p1_periph = {i_compare2_output, i_compare1_output, i_compare0_output, // RULE8
                        i_subsystem_master_clock,                                  // RULE7
                        i_compare2_output, i_compare1_output, i_compare0_output, // RULE5
                        PERIPH_LOW};                                               // RULE3
    assign p2_periph = {PERIPH_LOW, PERIPH_LOW,                                    // RULE14
                        PERIPH_LOW,                                                // RULE13
                        i_compare2_output, i_compare1_output,                      // RULE12
                        i_comparator_result,                                       // RULE11
                        PERIPH_LOW,                                                // RULE10
                        i_aux_clock};                                              // RULE9

    genvar g;
    generate
        for (g = 0; g < P1_W; g++)
        begin : g_p1
            ppm_slice_if sif ();

            ppm_sync3 u_sync (
                .i_ref_clk (i_ref_clk),
                .i_reset   (i_reset),
                .i_async   (i_p1_pin[g]),
                .o_value   (p1_sync[g])
            );

            assign sif.pin_function_select = i_p1_function_select[g]; // RULE1
            assign sif.pin_direction_bit   = i_p1_direction_bit[g];
            assign sif.pin_output_latch    = i_p1_output_latch[g];
            assign sif.pin_irq_enable      = i_p1_irq_enable[g];
            assign sif.pin_edge_select     = i_p1_edge_select[g];
            assign sif.periph_out          = p1_periph[g];
            assign sif.pin_sync            = p1_sync[g];
            assign sif.flag_wr             = i_p1_flag_wr;
            assign sif.flag_wdata          = i_p1_flag_wdata[g];
            assign p1_pad_out[g]           = sif.pad_out;
            assign p1_pad_oe[g]            = sif.pad_oe;
            assign o_p1_pin_input_value[g] = sif.pin_input_value;
            assign o_p1_pin_irq_flag[g]    = sif.pin_irq_flag;
            assign p1_req[g]               = sif.irq_req;

            ppm_pin_slice #(
                .HAS_PIN (1'b1)
            ) u_slice (
                .i_ref_clk (i_ref_clk),
                .i_reset   (i_reset),
                .sif       (sif)
            );
        end

        for (g = 0; g < P2_W; g++)
        begin : g_p2
            ppm_slice_if sif ();

            if (g < P2_BONDED)
            begin : g_pin
                ppm_sync3 u_sync (
                    .i_ref_clk (i_ref_clk),
                    .i_reset   (i_reset),
                    .i_async   (i_p2_pin[g]),
                    .o_value   (p2_sync[g])
                );
            end
            else
            begin : g_nopin
                assign p2_sync[g] = 1'b0; // RULE14
            end

            assign sif.pin_function_select = i_p2_function_select[g]; // RULE1
            assign sif.pin_direction_bit   = i_p2_direction_bit[g];
            assign sif.pin_output_latch    = i_p2_output_latch[g];
            assign sif.pin_irq_enable      = i_p2_irq_enable[g];
            assign sif.pin_edge_select     = i_p2_edge_select[g];
            assign sif.periph_out          = p2_periph[g];
            assign sif.pin_sync            = p2_sync[g];
            assign sif.flag_wr             = i_p2_flag_wr;
            assign sif.flag_wdata          = i_p2_flag_wdata[g];
            assign p2_pad_out[g]           = sif.pad_out;
            assign p2_pad_oe[g]            = sif.pad_oe;
            assign o_p2_pin_input_value[g] = sif.pin_input_value;
            assign o_p2_pin_irq_flag[g]    = sif.pin_irq_flag;
            assign p2_req[g]               = sif.irq_req;

            ppm_pin_slice #(
                .HAS_PIN (g < P2_BONDED)
            ) u_slice (
                .i_ref_clk (i_ref_clk),
                .i_reset   (i_reset),
                .sif       (sif)
            );
        end
    endgenerate

    // pads; unbonded port 2 bits have their slice but no pad
    assign o_p1_pin    = p1_pad_out;
    assign o_p1_pin_oe = p1_pad_oe;                  // RULE2
    assign o_p2_pin    = p2_pad_out[P2_BONDED-1:0];
    assign o_p2_pin_oe = p2_pad_oe[P2_BONDED-1:0];   // RULE2

    // unbonded flags raise requests like any other, which makes them software interrupts
    assign o_p1_irq = |p1_req;
    assign o_p2_irq = |p2_req;                       // RULE15

    // peripheral inputs take the filtered pin level whatever the select bit says
    assign o_timer_ext_clock_in = p1_sync[P1_EXT_CLK_BIT];  // RULE4
    assign o_capture0_input_a   = p1_sync[P1_CAP0_BIT];     // RULE6
    assign o_capture1_input_a   = p1_sync[P1_CAP1_BIT];     // RULE6
    assign o_capture2_input_a   = p1_sync[P1_CAP2_BIT];     // RULE6
    assign o_timer_alt_clock_in = p2_sync[P2_ALT_CLK_BIT];  // RULE10
    assign o_capture0_input_b   = p2_sync[P2_COMP_BIT];     // RULE11
    // tells the clock generator the resistor pin is claimed; the analog path is outside this block
    assign o_oscillator_resistor_pin = i_p2_function_select[P2_OSC_RES_BIT]; // RULE13
endmodule

// file: bench/ppm_periph_model.sv
// source model of the timer, clock and comparator outputs feeding the port mux
// assumes one clock; forwarded clocks are modelled as divided levels on that clock
`timescale 1ns/1ps
module ppm_periph_model
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    // sources
    output logic      o_compare0_output,
    output logic      o_compare1_output,
    output logic      o_compare2_output,
    output logic      o_subsystem_master_clock,
    output logic      o_aux_clock,
    output logic      o_comparator_result
);
    typedef struct packed {
        logic [4:0] cnt;
    } ppm_model_st_t;
    ppm_model_st_t st_q;
    ppm_model_st_t st_d;
    always_comb
    begin
        st_d = st_q;
        st_d.cnt = st_q.cnt + 5'h01;
    end
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    // every source gets its own pattern so a swapped route shows up
    assign o_subsystem_master_clock = st_q.cnt[0];
    assign o_compare0_output        = st_q.cnt[1];
    assign o_compare1_output        = st_q.cnt[2];
    assign o_compare2_output        = st_q.cnt[3];
    assign o_comparator_result      = st_q.cnt[4];
    assign o_aux_clock              = st_q.cnt[2] ^ st_q.cnt[0];
endmodule

// file: bench/ppm_port_mux_chk.sv
// assertions on the port mux top ports
// assumes the package bit map and widths of 8
`timescale 1ns/1ps
module ppm_port_mux_chk
    import ppm_pkg::*;
#(
    parameter int P1_W = 8,
    parameter int P2_W = 8
)
(
    // clock and reset
    input wire logic                 i_ref_clk,
    input wire logic                 i_reset,
    // control
    input wire logic [P1_W-1:0]      i_p1_function_select,
    input wire logic [P1_W-1:0]      i_p1_direction_bit,
    input wire logic [P1_W-1:0]      i_p1_output_latch,
    input wire logic [P1_W-1:0]      i_p1_irq_enable,
    input wire logic [P1_W-1:0]      i_p1_edge_select,
    input wire logic [P2_W-1:0]      i_p2_function_select,
    input wire logic [P2_W-1:0]      i_p2_direction_bit,
    input wire logic [P2_W-1:0]      i_p2_output_latch,
    input wire logic                 i_p2_flag_wr,
    input wire logic [P2_W-1:0]      i_p2_flag_wdata,
    // status and pads
    input wire logic [P1_W-1:0]      o_p1_pin_input_value,
    input wire logic [P1_W-1:0]      o_p1_pin_irq_flag,
    input wire logic                 o_p1_irq,
    input wire logic [P2_W-1:0]      o_p2_pin_input_value,
    input wire logic [P2_W-1:0]      o_p2_pin_irq_flag,
    input wire logic [P1_W-1:0]      o_p1_pin,
    input wire logic [P1_W-1:0]      o_p1_pin_oe,
    input wire logic [P2_BONDED-1:0] o_p2_pin,
    input wire logic [P2_BONDED-1:0] o_p2_pin_oe,
    // peripheral sources
    input wire logic                 i_compare0_output,
    input wire logic                 i_compare1_output,
    input wire logic                 i_compare2_output,
    input wire logic                 i_subsystem_master_clock,
    input wire logic                 i_aux_clock,
    input wire logic                 i_comparator_result
);
    logic [7:0] p1x;
    logic [5:0] p2x;
    assign p1x = {i_compare2_output, i_compare1_output, i_compare0_output, i_subsystem_master_clock,
                  i_compare2_output, i_compare1_output, i_compare0_output, PERIPH_LOW};
    assign p2x = {PERIPH_LOW, i_compare2_output, i_compare1_output, i_comparator_result, PERIPH_LOW, i_aux_clock};
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    property p_oe; {o_p1_pin_oe, o_p2_pin_oe} == {i_p1_direction_bit, i_p2_direction_bit[5:0]}; endproperty
    a_oe: assert property (p_oe) else $error("pad enable differs from direction");
    property p_p1_mux; o_p1_pin == ((i_p1_function_select & p1x) | (~i_p1_function_select & i_p1_output_latch)); endproperty
    a_p1_mux: assert property (p_p1_mux) else $error("port 1 pad value wrong");
    property p_p2_mux; o_p2_pin == ((i_p2_function_select[5:0] & p2x) | (~i_p2_function_select[5:0] & i_p2_output_latch[5:0])); endproperty
    a_p2_mux: assert property (p_p2_mux) else $error("port 2 pad value wrong");
    property p_unbonded_in; o_p2_pin_input_value[7:6] == 2'h0; endproperty
    a_unbonded_in: assert property (p_unbonded_in) else $error("unbonded input not low");
    property p_flag_hold; !i_p2_flag_wr |=> $stable(o_p2_pin_irq_flag[7:6]); endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("unbonded flag moved without write");
    property p_flag_wr; i_p2_flag_wr |=> o_p2_pin_irq_flag[7:6] == $past(i_p2_flag_wdata[7:6]); endproperty
    a_flag_wr: assert property (p_flag_wr) else $error("unbonded flag write lost");
    property p_irq; o_p1_irq == |(o_p1_pin_irq_flag & i_p1_irq_enable); endproperty
    a_irq: assert property (p_irq) else $error("port 1 request wrong");
    property p_rise; $rose(o_p1_pin_input_value[0]) && !i_p1_edge_select[0] |=> o_p1_pin_irq_flag[0]; endproperty
    a_rise: assert property (p_rise) else $error("rising edge did not set flag");
    c_wr: cover property (i_p2_flag_wr && i_p2_flag_wdata[7]);
    c_irq: cover property (o_p1_irq);
    c_periph: cover property (&i_p1_function_select && |i_p1_direction_bit);
endmodule
bind ppm_port_mux ppm_port_mux_chk #(.P1_W(P1_W), .P2_W(P2_W)) i_chk (.*);

// file: bench/ppm_port_mux_tb_top.sv
// self-checking bench for the port pin function multiplexer
// assumes the source model drives the peripheral inputs; checker is bound on its own
`timescale 1ns/1ps
module ppm_port_mux_tb_top;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_p1_flag_wr, i_p2_flag_wr, o_p1_irq, o_p2_irq;
    logic i_compare0_output, i_compare1_output, i_compare2_output, i_subsystem_master_clock, i_aux_clock;
    logic i_comparator_result, o_timer_ext_clock_in, o_timer_alt_clock_in, o_oscillator_resistor_pin;
    logic o_capture0_input_a, o_capture1_input_a, o_capture2_input_a, o_capture0_input_b;
    logic [7:0] i_p1_function_select, i_p1_direction_bit, i_p1_output_latch, i_p1_irq_enable, i_p1_edge_select;
    logic [7:0] i_p2_function_select, i_p2_direction_bit, i_p2_output_latch, i_p2_irq_enable, i_p2_edge_select;
    logic [7:0] i_p1_flag_wdata, i_p2_flag_wdata, i_p1_pin, o_p1_pin, o_p1_pin_oe;
    logic [7:0] o_p1_pin_input_value, o_p1_pin_irq_flag, o_p2_pin_input_value, o_p2_pin_irq_flag;
    logic [5:0] i_p2_pin, o_p2_pin, o_p2_pin_oe;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    ppm_port_mux i_dut (.*);
    ppm_periph_model i_src (
        .i_ref_clk                (i_ref_clk),
        .i_reset                  (i_reset),
        .o_compare0_output        (i_compare0_output),
        .o_compare1_output        (i_compare1_output),
        .o_compare2_output        (i_compare2_output),
        .o_subsystem_master_clock (i_subsystem_master_clock),
        .o_aux_clock              (i_aux_clock),
        .o_comparator_result      (i_comparator_result)
    );
    always #5 i_ref_clk = ~i_ref_clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // run is about 90 cycles; the ceiling only catches a hang
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wr_flags(input logic [7:0] d1, input logic [7:0] d2);
        i_p1_flag_wdata = d1;
        i_p2_flag_wdata = d2;
        i_p1_flag_wr = 1'b1;
        i_p2_flag_wr = 1'b1;
        step(1);
        i_p1_flag_wr = 1'b0;
        i_p2_flag_wr = 1'b0;
    endtask
    task automatic t_pad_mux();
        logic [7:0] p1x;
        logic [5:0] p2x;
        for (int k = 0; k < 8; k++)
        begin
            i_p1_function_select = k[1] ? 8'hFF : 8'h00;
            i_p2_function_select = k[1] ? 8'h3F : 8'hC0;
            i_p1_output_latch = k[0] ? 8'hA5 : 8'h5A;
            i_p2_output_latch = k[0] ? 8'h5A : 8'hA5;
            i_p1_direction_bit = k[2] ? 8'hFF : 8'h3C;
            i_p2_direction_bit = k[2] ? 8'h0F : 8'hF0;
            repeat (4)
            begin
                #2;
                p1x = {i_compare2_output, i_compare1_output, i_compare0_output, i_subsystem_master_clock,
                       i_compare2_output, i_compare1_output, i_compare0_output, 1'b0};
                p2x = {1'b0, i_compare2_output, i_compare1_output, i_comparator_result, 1'b0, i_aux_clock};
                chk("p1 pad", (i_p1_function_select & p1x) | (~i_p1_function_select & i_p1_output_latch), o_p1_pin);
                chk("p2 pad", {2'h0, (i_p2_function_select[5:0] & p2x) | (~i_p2_function_select[5:0] & i_p2_output_latch[5:0])}, {2'h0, o_p2_pin});
                chk("oe", {i_p1_direction_bit[3:0], i_p2_direction_bit[3:0]}, {o_p1_pin_oe[3:0], o_p2_pin_oe[3:0]});
                chk("oe hi", {i_p1_direction_bit[7:4], 2'h0, i_p2_direction_bit[5:4]}, {o_p1_pin_oe[7:4], 2'h0, o_p2_pin_oe[5:4]});
                chk("osc", {7'h00, i_p2_function_select[5]}, {7'h00, o_oscillator_resistor_pin});
                step(1);
            end
        end
    endtask
    task automatic t_input_route();
        logic [7:0] v;
        for (int k = 0; k < 4; k++)
        begin
            v = (k == 0) ? 8'hA5 : (k == 1) ? 8'h5A : (k == 2) ? 8'hFF : 8'h00;
            i_p1_pin = v;
            i_p2_pin = ~v[5:0];
            i_p1_function_select = ~v;
            step(4);
            chk("p1 in", v, o_p1_pin_input_value);
            chk("p2 in", {2'h0, ~v[5:0]}, o_p2_pin_input_value);
            chk("sinks", {2'h0, v[0], ~v[1], v[1], v[2], v[3], ~v[2]}, {2'h0, o_timer_ext_clock_in,
                o_timer_alt_clock_in, o_capture0_input_a, o_capture1_input_a, o_capture2_input_a,
                o_capture0_input_b});
        end
    endtask
    task automatic t_edge_flags();
        i_p1_edge_select = 8'hAA;
        i_p2_edge_select = 8'hAA;
        i_p1_irq_enable = 8'hAA;
        // let edges left by the routing test land before clearing, since a set beats a clear
        i_p2_pin = 6'h00;
        step(5);
        wr_flags(8'h00, 8'h00);
        chk("p1 flag clr", 8'h00, o_p1_pin_irq_flag);
        i_p1_pin = 8'hFF;
        i_p2_pin = 6'h3F;
        step(6);
        chk("p1 rise", 8'h55, o_p1_pin_irq_flag);
        chk("p2 rise", 8'h15, o_p2_pin_irq_flag);
        chk("masked irq", 8'h00, {7'h00, o_p1_irq});
        i_p1_pin = 8'h00;
        i_p2_pin = 6'h00;
        step(6);
        chk("p1 fall", 8'hFF, o_p1_pin_irq_flag);
        chk("p2 fall", 8'h3F, o_p2_pin_irq_flag);
        chk("irq", 8'h01, {7'h00, o_p1_irq});
    endtask
    task automatic t_sw_flags();
        i_p2_irq_enable = 8'h80;
        wr_flags(8'h00, 8'hC0);
        chk("sw flags", 8'hC0, o_p2_pin_irq_flag);
        chk("sw irq", 8'h01, {7'h00, o_p2_irq});
        i_p2_irq_enable = 8'h00;
        step(1);
        chk("sw irq off", 8'h00, {7'h00, o_p2_irq});
        i_p2_irq_enable = 8'h40;
        wr_flags(8'h00, 8'h40);
        chk("sw irq 6", 8'h01, {7'h00, o_p2_irq});
        step(1);
        wr_flags(8'h00, 8'h00);
        chk("sw clr", 8'h00, o_p2_pin_irq_flag);
    endtask
    initial
    begin
        {i_p1_function_select, i_p1_direction_bit, i_p1_output_latch, i_p1_irq_enable, i_p1_edge_select} = '0;
        {i_p2_function_select, i_p2_direction_bit, i_p2_output_latch, i_p2_irq_enable, i_p2_edge_select} = '0;
        {i_p1_flag_wr, i_p2_flag_wr, i_p1_flag_wdata, i_p2_flag_wdata, i_p1_pin, i_p2_pin} = '0;
        step(16);
        i_reset = 1'b0;
        step(1);
        t_pad_mux();
        t_input_route();
        t_edge_flags();
        t_sw_flags();
        final_report();
    end
endmodule
